// ---- design/pps_power_stage.sv ----
// Power protection stage: APB registers, power selection, pick-up with
// hysteresis, definite-time trip, mode and forcing, event interrupt.
// Assumes synchronous measurement inputs and a 50 MHz APB clock.
//
// How it works
// - Power from currents and LN or LL voltages
// - Measurements refreshed every 5 ms
// - Select active, reactive or apparent; active default
// - Nominal from manual, generator or transformer
// - Manual nominal 0.0001 MVA steps, 10 MVA
// - Over or under direction; over default
// - Signed pick-up in 0.005 % steps, zero
// - Each cycle compare measured power against threshold
// - Release at 97 % over, 103 % under
// - Act beyond maximum or below minimum
// - Mode On, Blocked, Test, Test/Blocked, Off
// - Forcing overrides status when globally enabled
// - Mode and forcing ignore setting group
// - Operating settings follow active group live
`timescale 1ns/1ps
`default_nettype none
module pps_power_stage
	import pps_pkg::*;
#(
	parameter int unsigned NGROUPS     = 8,                // Setting groups
	parameter int unsigned TICK_CYCLES = PPS_TICK_CYCLES   // Clocks per processing cycle
) (
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [11:0]          paddr,
	input  wire logic [31:0]          pwdata,
	output logic [31:0]               prdata,
	output logic                      pready,
	output logic                      pslverr,
	input  wire logic [15:0]          cur_l1,
	input  wire logic [15:0]          cur_l2,
	input  wire logic [15:0]          cur_l3,
	input  wire logic [15:0]          volt_1,
	input  wire logic [15:0]          volt_2,
	input  wire logic [15:0]          volt_3,
	input  wire logic signed [15:0]   cos_l1,
	input  wire logic signed [15:0]   cos_l2,
	input  wire logic signed [15:0]   cos_l3,
	input  wire logic signed [15:0]   sin_l1,
	input  wire logic signed [15:0]   sin_l2,
	input  wire logic signed [15:0]   sin_l3,
	input  wire logic [PPS_NOM_W-1:0] gen_nom_mva,
	input  wire logic [PPS_NOM_W-1:0] trafo_nom_mva,
	input  wire logic                 block_in,
	output logic                      start_out,
	output logic                      trip_out,
	output logic                      blocked_out,
	output logic                      test_out,
	output logic                      irq
);

	// Group index must fit the 3-bit group field
	if (NGROUPS < 1 || NGROUPS > 8) begin : g_bad
		$error("pps_power_stage: NGROUPS must be 1..8");
	end

	// Group of a per-group address, or all ones when outside the blocks
	function automatic logic [3:0] grp_of(input logic [11:0] a);
		logic [11:0] rel;
		rel = a - PPS_OFF_GRP_BASE;
		if (a < PPS_OFF_GRP_BASE || rel[11:4] >= 8'(NGROUPS)) begin
			return 4'hF;
		end
		return rel[7:4];
	endfunction : grp_of

	// Sign-extend a pick-up setting to the comparison width
	function automatic logic signed [63:0] sext_pick(input logic [PPS_PICK_W-1:0] v);
		return 64'($signed(v));
	endfunction : sext_pick

	// Static settings, not part of any group
	logic [2:0]             mode_r;       // Logical node mode
	logic [1:0]             force_r;      // Forced status
	logic                   force_en_r;   // Global forcing enable
	logic [2:0]             grp_r;        // Active setting group
	// Group settings, indexed by group
	logic [5:0]             cfg_r   [NGROUPS];
	logic [PPS_NOM_W-1:0]   nom_r   [NGROUPS];
	logic [PPS_PICK_W-1:0]  pick_r  [NGROUPS];
	logic [PPS_DELAY_W-1:0] dly_r   [NGROUPS];
	logic [PPS_EV_W-1:0]    ev_r;         // Sticky events
	logic [PPS_EV_W-1:0]    mask_r;       // Event enables
	logic [31:0]            prdata_nxt;
	logic                   pslverr_nxt;

	// Bus access decode
	logic                   wr_acc;
	logic                   rd_acc;
	logic [3:0]             acc_grp;
	logic [3:0]             acc_goff;
	logic                   acc_sta;      // Address names a static register

	assign pready   = 1'b1;               // Every access ends in its first access cycle
	assign wr_acc   = psel && penable && pwrite;
	assign rd_acc   = psel && penable && !pwrite;
	assign acc_grp  = grp_of(paddr);
	assign acc_goff = paddr[3:0];

	// Measurement path
	logic                          tick;
	logic                          meas_valid;
	logic signed [PPS_PWR_W-1:0]   p_tot;
	logic signed [PPS_PWR_W-1:0]   q_tot;
	logic signed [PPS_PWR_W-1:0]   s_tot;
	logic [5:0]                    cfg_act;   // Settings of the active group
	logic [PPS_NOM_W-1:0]          nom_used;
	logic signed [PPS_PWR_W-1:0]   meas_sel;

	assign cfg_act = cfg_r[grp_r];

	pps_tick #(
		.CYCLES (TICK_CYCLES)
	) u_tick (
		.pclk    (pclk),
		.presetn (presetn),
		.tick    (tick)
	);

	pps_power_calc u_calc (
		.pclk                 (pclk),
		.presetn              (presetn),
		.sample               (tick),
		.line_to_line         (cfg_act[PPS_CFG_LL]),
		.cur_l1               (cur_l1),
		.cur_l2               (cur_l2),
		.cur_l3               (cur_l3),
		.volt_1               (volt_1),
		.volt_2               (volt_2),
		.volt_3               (volt_3),
		.cos_l1               (cos_l1),
		.cos_l2               (cos_l2),
		.cos_l3               (cos_l3),
		.sin_l1               (sin_l1),
		.sin_l2               (sin_l2),
		.sin_l3               (sin_l3),
		.active_power_total   (p_tot),
		.reactive_power_total (q_tot),
		.apparent_power_total (s_tot),
		.valid                (meas_valid)
	);

	// Quantity and nominal selection from the active group
	always_comb begin
		case (cfg_act[PPS_CFG_MAG_LSB +: 2])
			PPS_MAG_REACTIVE: meas_sel = q_tot;
			PPS_MAG_APPARENT: meas_sel = s_tot;
			default:          meas_sel = p_tot;
		endcase
		case (cfg_act[PPS_CFG_REF_LSB +: 2])
			PPS_REF_GEN:   nom_used = gen_nom_mva;
			PPS_REF_TRAFO: nom_used = trafo_nom_mva;
			default:       nom_used = nom_r[grp_r];
		endcase
	end

	// Threshold test by cross-multiplication, so no divider is needed
	logic signed [63:0] meas_x;     // Measured power times pick-up scale
	logic signed [63:0] thr_x;      // Pick-up steps times nominal
	logic               under;
	logic               beyond;     // Past the operate limit
	logic               released;   // Back inside the release limit
	logic               picked_r;
	logic               picked_nxt;

	always_comb begin
		under    = cfg_act[PPS_CFG_UNDER];
		meas_x   = 64'(meas_sel) * 64'(PPS_PICK_SCALE);
		thr_x    = sext_pick(pick_r[grp_r]) * $signed({40'h0, nom_used});
		beyond   = under ? (meas_x < thr_x) : (meas_x > thr_x);
		released = under ? (meas_x * 64'(PPS_PCT) > thr_x * 64'(PPS_REL_UNDER))
		                 : (meas_x * 64'(PPS_PCT) < thr_x * 64'(PPS_REL_OVER));
		picked_nxt = picked_r;
		if (meas_valid) begin
			picked_nxt = picked_r ? !released : beyond;
		end
		if (mode_r > PPS_LN_TEST_BLOCKED) begin  // Codes 4-7 act as Off
			picked_nxt = 1'b0;
		end
	end

	// Stage condition and definite-time counter
	pps_cond_t              cond_r;
	pps_cond_t              cond_nxt;
	logic [PPS_DELAY_W-1:0] cnt_r;
	logic [PPS_DELAY_W-1:0] cnt_nxt;
	logic                   blk;

	always_comb begin
		blk      = block_in || mode_r == PPS_LN_BLOCKED || mode_r == PPS_LN_TEST_BLOCKED;
		cond_nxt = cond_r;
		cnt_nxt  = cnt_r;
		if (mode_r > PPS_LN_TEST_BLOCKED) begin
			cond_nxt = PPS_COND_NORMAL;
			cnt_nxt  = '0;
		end else if (meas_valid) begin
			if (!picked_nxt) begin
				cond_nxt = PPS_COND_NORMAL;
				cnt_nxt  = '0;
			end else if (blk) begin  // Blocking drops a running start
				cond_nxt = PPS_COND_BLOCKED;
				cnt_nxt  = '0;
			end else if (cond_r != PPS_COND_TRIP) begin
				cond_nxt = PPS_COND_START;
				if (cnt_r != '1) begin
					cnt_nxt = cnt_r + PPS_DELAY_W'(1);
				end
				if (cnt_nxt >= dly_r[grp_r]) begin
					cond_nxt = PPS_COND_TRIP;
				end
			end
		end
	end

	// Shown condition: forcing wins when globally enabled
	pps_cond_t show_nxt;
	pps_cond_t show_r;
	logic [PPS_EV_W-1:0] ev_set;

	always_comb begin
		show_nxt = force_en_r ? pps_cond_t'(force_r) : cond_nxt;
		ev_set   = '0;
		ev_set[PPS_EV_START_ON]  = show_nxt == PPS_COND_START && show_r != PPS_COND_START;
		ev_set[PPS_EV_START_OFF] = show_r == PPS_COND_START && show_nxt != PPS_COND_START;
		ev_set[PPS_EV_TRIP_ON]   = show_nxt == PPS_COND_TRIP && show_r != PPS_COND_TRIP;
		ev_set[PPS_EV_TRIP_OFF]  = show_r == PPS_COND_TRIP && show_nxt != PPS_COND_TRIP;
		ev_set[PPS_EV_BLK_ON]    = show_nxt == PPS_COND_BLOCKED && show_r != PPS_COND_BLOCKED;
		ev_set[PPS_EV_BLK_OFF]   = show_r == PPS_COND_BLOCKED && show_nxt != PPS_COND_BLOCKED;
	end

	// Protection state registers; start, trip and blocked outputs follow the shown condition, test_out the mode, irq the events
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			picked_r    <= 1'b0;
			cond_r      <= PPS_COND_NORMAL;
			show_r      <= PPS_COND_NORMAL;
			cnt_r       <= '0;
			start_out   <= 1'b0;
			trip_out    <= 1'b0;
			blocked_out <= 1'b0;
			test_out    <= 1'b0;
			irq         <= 1'b0;
		end else begin
			picked_r    <= picked_nxt;
			cond_r      <= cond_nxt;
			show_r      <= show_nxt;
			cnt_r       <= cnt_nxt;
			start_out   <= show_nxt == PPS_COND_START || show_nxt == PPS_COND_TRIP;
			trip_out    <= show_nxt == PPS_COND_TRIP;
			blocked_out <= show_nxt == PPS_COND_BLOCKED;
			test_out    <= mode_r == PPS_LN_TEST || mode_r == PPS_LN_TEST_BLOCKED;
			irq         <= |(ev_r & mask_r);
		end
	end

	// Register read mux and error answer
	always_comb begin
		prdata_nxt  = 32'h0000_0000;
		pslverr_nxt = 1'b0;
		acc_sta     = 1'b1;
		case (paddr)
			PPS_OFF_CTRL:     prdata_nxt = {26'h0, force_en_r, force_r, mode_r};
			PPS_OFF_GROUP:    prdata_nxt = {29'h0, grp_r};
			PPS_OFF_STATUS:   prdata_nxt = {27'h0, blocked_out, trip_out, start_out, show_r};
			PPS_OFF_IRQ_STAT: prdata_nxt = {26'h0, ev_r};
			PPS_OFF_IRQ_MASK: prdata_nxt = {26'h0, mask_r};
			PPS_OFF_MEAS:     prdata_nxt = meas_sel[31:0];
			PPS_OFF_NOM_USED: prdata_nxt = {8'h00, nom_used};
			default:          acc_sta    = 1'b0;
		endcase
		if (!acc_sta) begin
			if (acc_grp == 4'hF) begin
				pslverr_nxt = 1'b1;  // Unmapped address
			end else begin
				case (acc_goff)
					PPS_GOFF_CFG:   prdata_nxt = {26'h0, cfg_r[acc_grp[2:0]]};
					PPS_GOFF_NOM:   prdata_nxt = {8'h00, nom_r[acc_grp[2:0]]};
					PPS_GOFF_PICK:  prdata_nxt = 32'(sext_pick(pick_r[acc_grp[2:0]]));
					PPS_GOFF_DELAY: prdata_nxt = {16'h0000, dly_r[acc_grp[2:0]]};
					default:        pslverr_nxt = 1'b1;
				endcase
			end
		end
		if (!(psel && penable)) begin
			prdata_nxt  = 32'h0000_0000;
			pslverr_nxt = 1'b0;
		end
	end

	assign pslverr = pslverr_nxt;
	assign prdata  = pwrite ? 32'h0000_0000 : prdata_nxt;  // Data only on reads

	// Software-written registers; a new event beats a clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_r     <= PPS_LN_ON;
			force_r    <= PPS_COND_NORMAL;
			force_en_r <= 1'b0;
			grp_r      <= 3'h0;
			ev_r       <= '0;
			mask_r     <= '0;
			for (int g = 0; g < NGROUPS; g++) begin
				cfg_r[g]  <= PPS_CFG_RST;
				nom_r[g]  <= PPS_NOM_RST;
				pick_r[g] <= PPS_PICK_RST;
				dly_r[g]  <= PPS_DELAY_RST;
			end
		end else begin
			ev_r <= (wr_acc && paddr == PPS_OFF_IRQ_STAT) ? ((ev_r & ~pwdata[PPS_EV_W-1:0]) | ev_set)
			                                             : (ev_r | ev_set);
			if (wr_acc) begin
				case (paddr)
					PPS_OFF_CTRL: begin
						mode_r     <= pwdata[PPS_CTRL_MODE_LSB +: 3];
						force_r    <= pwdata[PPS_CTRL_FORCE_LSB +: 2];
						force_en_r <= pwdata[PPS_CTRL_FORCE_EN];
					end
					PPS_OFF_GROUP: begin
						if (pwdata < 32'(NGROUPS)) begin
							grp_r <= pwdata[2:0];
						end
					end
					PPS_OFF_IRQ_MASK: mask_r <= pwdata[PPS_EV_W-1:0];
					default: begin
						if (acc_grp != 4'hF) begin
							case (acc_goff)
								PPS_GOFF_CFG:   cfg_r[acc_grp[2:0]]  <= pwdata[5:0];
								PPS_GOFF_NOM:   nom_r[acc_grp[2:0]]  <= pwdata[PPS_NOM_W-1:0];
								PPS_GOFF_PICK:  pick_r[acc_grp[2:0]] <= pwdata[PPS_PICK_W-1:0];
								PPS_GOFF_DELAY: dly_r[acc_grp[2:0]]  <= pwdata[PPS_DELAY_W-1:0];
								default:        ;
							endcase
						end
					end
				endcase
			end
		end
	end

endmodule : pps_power_stage
`default_nettype wire

// ---- design/pps_pkg.sv ----
// Package of the power protection stage: register map, field layout,
// reset values, encodings and timing constants.
// Assumes a 50 MHz APB clock and 32-bit APB data.
package pps_pkg;

	// Clock and processing time base
	localparam int unsigned PPS_CLK_HZ      = 50_000_000;  // Bus and logic clock rate
	localparam int unsigned PPS_TICK_MS     = 5;           // Processing cycle in ms
	localparam int unsigned PPS_TICK_CYCLES = PPS_CLK_HZ / 1000 * PPS_TICK_MS;

	// Register byte offsets, static part
	localparam logic [11:0] PPS_OFF_CTRL     = 12'h000;   // Mode and forcing, static
	localparam logic [11:0] PPS_OFF_GROUP    = 12'h004;   // Active setting group
	localparam logic [11:0] PPS_OFF_STATUS   = 12'h00C;   // Stage condition, read only
	localparam logic [11:0] PPS_OFF_IRQ_STAT = 12'h010;   // Sticky events, write one to clear
	localparam logic [11:0] PPS_OFF_IRQ_MASK = 12'h014;   // Event enables
	localparam logic [11:0] PPS_OFF_MEAS     = 12'h018;   // Selected power, read only
	localparam logic [11:0] PPS_OFF_NOM_USED = 12'h01C;   // Nominal power in use, read only
	// Per-group blocks: base plus group times stride
	localparam logic [11:0] PPS_OFF_GRP_BASE = 12'h040;
	localparam logic [11:0] PPS_GRP_STRIDE   = 12'h010;
	localparam logic [3:0]  PPS_GOFF_CFG     = 4'h0;      // Magnitude, reference, direction
	localparam logic [3:0]  PPS_GOFF_NOM     = 4'h4;      // Manual nominal, 0.0001 MVA steps
	localparam logic [3:0]  PPS_GOFF_PICK    = 4'h8;      // Signed pick-up, 0.005 % steps
	localparam logic [3:0]  PPS_GOFF_DELAY   = 4'hC;      // Trip delay in processing cycles

	// Field positions
	localparam int PPS_CTRL_MODE_LSB  = 0;   // Logical node mode, 3 bits
	localparam int PPS_CTRL_FORCE_LSB = 3;   // Forced status, 2 bits
	localparam int PPS_CTRL_FORCE_EN  = 5;   // Global forcing enable
	localparam int PPS_CFG_MAG_LSB    = 0;   // Measured magnitude, 2 bits
	localparam int PPS_CFG_REF_LSB    = 2;   // Nominal reference, 2 bits
	localparam int PPS_CFG_UNDER      = 4;   // Pick-up direction, 1 = under
	localparam int PPS_CFG_LL         = 5;   // Voltages are line-to-line

	// Field widths
	localparam int PPS_NOM_W   = 24;         // Up to 1000 MVA in 0.0001 MVA steps
	localparam int PPS_PICK_W  = 18;         // +/-500 % in 0.005 % steps
	localparam int PPS_DELAY_W = 16;         // Trip delay, processing cycles
	localparam int PPS_PWR_W   = 40;         // Power totals, 0.0001 MVA steps

	// Reset values
	localparam logic [PPS_NOM_W-1:0]   PPS_NOM_RST   = 24'h01_86A0;  // 10 MVA
	localparam logic [PPS_PICK_W-1:0]  PPS_PICK_RST  = 18'h0_0000;   // 0 %
	localparam logic [PPS_DELAY_W-1:0] PPS_DELAY_RST = 16'h0000;     // Instant
	localparam logic [5:0]             PPS_CFG_RST   = 6'h00;        // Active, manual, over, LN

	// Comparison scaling
	localparam int PPS_PICK_SCALE = 20000;   // Pick-up steps per unit of nominal
	localparam int PPS_REL_OVER   = 97;      // Release ratio in over mode, percent
	localparam int PPS_REL_UNDER  = 103;     // Release ratio in under mode, percent
	localparam int PPS_PCT        = 100;
	localparam logic [15:0] PPS_INV_SQRT3_Q15 = 16'h49E7;  // 1/sqrt(3) in Q1.15

	// Event bits in the sticky status register
	localparam int PPS_EV_START_ON  = 0;
	localparam int PPS_EV_START_OFF = 1;
	localparam int PPS_EV_TRIP_ON   = 2;
	localparam int PPS_EV_TRIP_OFF  = 3;
	localparam int PPS_EV_BLK_ON    = 4;
	localparam int PPS_EV_BLK_OFF   = 5;
	localparam int PPS_EV_W         = 6;

	// Encodings
	typedef enum logic [1:0] {
		PPS_MAG_ACTIVE   = 2'b00,
		PPS_MAG_REACTIVE = 2'b01,
		PPS_MAG_APPARENT = 2'b10
	} pps_mag_t;

	typedef enum logic [1:0] {
		PPS_REF_MANUAL = 2'b00,
		PPS_REF_GEN    = 2'b01,
		PPS_REF_TRAFO  = 2'b10
	} pps_ref_t;

	typedef enum logic [2:0] {
		PPS_LN_ON           = 3'b000,
		PPS_LN_BLOCKED      = 3'b001,
		PPS_LN_TEST         = 3'b010,
		PPS_LN_TEST_BLOCKED = 3'b011,
		PPS_LN_OFF          = 3'b100
	} pps_logical_node_mode_t;

	typedef enum logic [1:0] {
		PPS_COND_NORMAL  = 2'b00,
		PPS_COND_START   = 2'b01,
		PPS_COND_TRIP    = 2'b10,
		PPS_COND_BLOCKED = 2'b11
	} pps_cond_t;

endpackage : pps_pkg

// ---- design/pps_tick.sv ----
// Divider that makes the 5 ms processing pulse.
// Assumes one free-running clock; the pulse is one clock wide.
`timescale 1ns/1ps
`default_nettype none
module pps_tick
	import pps_pkg::*;
#(
	parameter int unsigned CYCLES = PPS_TICK_CYCLES  // Clocks per processing cycle
) (
	input  wire logic pclk,
	input  wire logic presetn,
	output logic      tick
);

	// Refuse a divider the counter cannot hold
	if (CYCLES < 2 || CYCLES > 32'h00FF_FFFF) begin : g_bad
		$error("pps_tick: CYCLES out of range");
	end

	localparam logic [23:0] LAST = 24'(CYCLES - 1);

	logic [23:0] cnt_r;    // Clocks within the cycle
	logic [23:0] cnt_nxt;
	logic        tick_nxt;

	// Wrap at the end of each cycle and flag it
	always_comb begin
		tick_nxt = (cnt_r == LAST);
		cnt_nxt  = tick_nxt ? 24'h00_0000 : cnt_r + 24'h00_0001;
	end

	// Registered so the pulse comes from a flip-flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= 24'h00_0000;
			tick  <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			tick  <= tick_nxt;
		end
	end

endmodule : pps_tick
`default_nettype wire

// ---- design/pps_power_calc.sv ----
// Three-phase power totals from phase magnitudes and phase angle terms.
// Assumes currents in amperes, voltages in 100 V steps, cos and sin in Q1.15.
`timescale 1ns/1ps
`default_nettype none
module pps_power_calc
	import pps_pkg::*;
(
	input  wire logic                        pclk,
	input  wire logic                        presetn,
	input  wire logic                        sample,
	input  wire logic                        line_to_line,
	input  wire logic [15:0]                 cur_l1,
	input  wire logic [15:0]                 cur_l2,
	input  wire logic [15:0]                 cur_l3,
	input  wire logic [15:0]                 volt_1,
	input  wire logic [15:0]                 volt_2,
	input  wire logic [15:0]                 volt_3,
	input  wire logic signed [15:0]          cos_l1,
	input  wire logic signed [15:0]          cos_l2,
	input  wire logic signed [15:0]          cos_l3,
	input  wire logic signed [15:0]          sin_l1,
	input  wire logic signed [15:0]          sin_l2,
	input  wire logic signed [15:0]          sin_l3,
	output logic signed [PPS_PWR_W-1:0]      active_power_total,
	output logic signed [PPS_PWR_W-1:0]      reactive_power_total,
	output logic signed [PPS_PWR_W-1:0]      apparent_power_total,
	output logic                             valid
);

	// Latched snapshot of one processing cycle
	logic [15:0]        cur_r   [3];
	logic [15:0]        volt_r  [3];
	logic signed [15:0] cos_r   [3];
	logic signed [15:0] sin_r   [3];
	logic               ll_r;
	logic               pend_r;   // Snapshot waiting for arithmetic
	logic signed [PPS_PWR_W-1:0] p_nxt;
	logic signed [PPS_PWR_W-1:0] q_nxt;
	logic signed [PPS_PWR_W-1:0] s_nxt;

	// Sum the phases; line-to-line voltages are brought to phase level
	always_comb begin
		logic signed [63:0] ui;
		logic signed [63:0] pa;
		logic signed [63:0] qa;
		logic signed [63:0] sa;
		ui = 64'sh0;
		pa = 64'sh0;
		qa = 64'sh0;
		sa = 64'sh0;
		for (int k = 0; k < 3; k++) begin
			ui = $signed({32'h0000_0000, 32'(cur_r[k]) * 32'(volt_r[k])});  // Full-width product
			if (ll_r) begin
				ui = (ui * $signed({48'h0, PPS_INV_SQRT3_Q15})) >>> 15;
			end
			pa = pa + ((ui * 64'(cos_r[k])) >>> 15);
			qa = qa + ((ui * 64'(sin_r[k])) >>> 15);
			sa = sa + ui;
		end
		p_nxt = PPS_PWR_W'(pa);
		q_nxt = PPS_PWR_W'(qa);
		s_nxt = PPS_PWR_W'(sa);
	end

	// Inputs are taken only on the processing pulse, results one clock later
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int k = 0; k < 3; k++) begin
				cur_r[k]  <= 16'h0000;
				volt_r[k] <= 16'h0000;
				cos_r[k]  <= 16'h0000;
				sin_r[k]  <= 16'h0000;
			end
			ll_r                 <= 1'b0;
			pend_r               <= 1'b0;
			valid                <= 1'b0;
			active_power_total   <= '0;
			reactive_power_total <= '0;
			apparent_power_total <= '0;
		end else begin
			pend_r <= sample;
			valid  <= pend_r;
			if (sample) begin
				cur_r[0]  <= cur_l1;
				cur_r[1]  <= cur_l2;
				cur_r[2]  <= cur_l3;
				volt_r[0] <= volt_1;
				volt_r[1] <= volt_2;
				volt_r[2] <= volt_3;
				cos_r[0]  <= cos_l1;
				cos_r[1]  <= cos_l2;
				cos_r[2]  <= cos_l3;
				sin_r[0]  <= sin_l1;
				sin_r[1]  <= sin_l2;
				sin_r[2]  <= sin_l3;
				ll_r      <= line_to_line;
			end
			if (pend_r) begin
				active_power_total   <= p_nxt;
				reactive_power_total <= q_nxt;
				apparent_power_total <= s_nxt;
			end
		end
	end

endmodule : pps_power_calc
`default_nettype wire

// ---- verification/pps_power_stage_properties.sv ----
// Port checker for the power stage.
// Assumes one clock and the active-low bus reset.
`timescale 1ns/1ps
`default_nettype none
module pps_chk (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        start_out,
	input wire logic        trip_out,
	input wire logic        blocked_out,
	input wire logic        irq
);
	// One domain, so one clock and one reset for all
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Bus answers
	AST_PREADY: assert property (pready) else $error("wait state");
	AST_RD_IDLE: assert property (!(psel && penable && !pwrite) |-> prdata == 0) else $error("stray data");
	AST_ERR_PHASE: assert property (!(psel && penable) |-> !pslverr) else $error("stray error");
	AST_ERR_DATA: assert property (pslverr |-> prdata == 0) else $error("data on error");
	// Condition outputs are one of four states
	AST_TRIP_START: assert property (trip_out |-> start_out) else $error("trip alone");
	AST_BLK_EXCL: assert property (blocked_out |-> !start_out) else $error("blocked with start");
	AST_BLK_NOTRIP: assert property (blocked_out |-> !trip_out) else $error("blocked with trip");
	// Nothing can act in the first two cycles after reset
	AST_RST_QUIET: assert property ($rose(presetn) |-> !(start_out || trip_out || blocked_out || irq) [*2])
		else $error("output after reset");
	// Main scenarios
	cover property ($rose(trip_out));
	cover property ($rose(blocked_out));
	cover property ($rose(irq));
endmodule : pps_chk
bind pps_power_stage pps_chk i_chk (.pclk, .presetn, .psel, .penable, .pwrite, .prdata, .pready, .pslverr,
	.start_out, .trip_out, .blocked_out, .irq);
`default_nettype wire

// ---- verification/pps_meas_model.sv ----
// Front-end model: phase current, voltage and angle terms.
// Assumes the bench sets the current; all phases alike.
`timescale 1ns/1ps
`default_nettype none
module pps_meas_model #(
	parameter int PER = 20  // Clocks per refresh
) (
	input  wire logic          pclk,
	input  wire logic   [15:0] amps,
	output logic        [15:0] cur,
	output logic        [15:0] volt,
	output logic signed [15:0] cosv,
	output logic signed [15:0] sinv
);
	int cnt = 0;  // Refresh phase, free of the stage's own divider
	// Magnitudes change only once per processing period
	always @(posedge pclk) begin
		cnt <= (cnt == PER - 1) ? 0 : cnt + 1;
		if (cnt == 0)
			cur <= amps;
	end
	// 10 kV, cos 0.5, sin 0.25 on each phase
	assign volt = 16'h0064;
	assign cosv = 16'h4000;
	assign sinv = 16'h2000;
endmodule : pps_meas_model
`default_nettype wire

// ---- verification/pps_power_stage_test.sv ----
// Bench for the power stage: bus tasks, then settings and checks.
// Assumes a processing cycle shortened to 20 clocks.
`timescale 1ns/1ps
`default_nettype none
module pps_power_stage_test;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, block_in = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, q;
	logic pready, pslverr, start_out, trip_out, blocked_out, test_out, irq, e;
	logic [15:0] amps = 0, cur, volt;
	logic signed [15:0] cosv, sinv;
	int errors = 0, samples_checked = 0;
	// 50 MHz clock, front end and stage
	initial forever #10 pclk = ~pclk;
	pps_meas_model i_fe (.pclk, .amps, .cur, .volt, .cosv, .sinv);
	pps_power_stage #(.NGROUPS(8), .TICK_CYCLES(20)) i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .cur_l1(cur), .cur_l2(cur), .cur_l3(cur), .volt_1(volt),
		.volt_2(volt), .volt_3(volt), .cos_l1(cosv), .cos_l2(cosv), .cos_l3(cosv), .sin_l1(sinv),
		.sin_l2(sinv), .sin_l3(sinv), .gen_nom_mva(24'h00_C350), .trafo_nom_mva(24'h03_0D40), .block_in,
		.start_out, .trip_out, .blocked_out, .test_out, .irq);
	// Compare and count
	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
		samples_checked++;
		if (g !== x) begin
			errors++;
			$display("Error %s expected %h seen %h", n, x, g);
		end
	endtask : chk
	// Counts, verdict, end of run
	task automatic finish_test;
		$display("checks %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : finish_test
	// One transfer, request held until pready is seen
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		@(posedge pclk);
		for (n = 0; n < 9 && pready !== 1'b1; n++) @(posedge pclk);
		chk("ready", 1, pready);
		if (n == 9) finish_test;
		q = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask : apb
	task automatic rdc(input string n, input logic [11:0] a, input logic [31:0] x);
		apb(0, a, 0);
		chk(n, x, q);
	endtask : rdc
	// New current, then k clocks
	task automatic amp(input logic [15:0] v, input int k);
		amps <= v;
		repeat (k) @(posedge pclk);
	endtask : amp
	initial begin
		logic [31:0] pe [4];
		logic [31:0] pn [3];
		int n;
		pe = '{20'h1_9A28, 20'h0_CD14, 20'h3_3450, 20'h0_ECCD};
		pn = '{20'h1_86A0, 20'h0_C350, 20'h3_0D40};
		repeat (6) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		rdc("ctrl", 12'h000, 0);
		rdc("cfg", 12'h040, 0);
		rdc("nom", 12'h044, 20'h1_86A0);
		rdc("pick", 12'h048, 0);
		apb(0, 12'h008, 0);
		chk("slverr", 1, e);
		$display("reset done");
		apb(1, 12'h048, 16'h4E20);
		apb(1, 12'h04C, 3);
		for (int i = 0; i < 4; i++) begin
			apb(1, 12'h040, i < 3 ? i : 6'h20);
			amp(16'h02BC, 60);
			rdc("meas", 12'h018, pe[i]);
		end
		for (int i = 0; i < 3; i++) begin
			apb(1, 12'h040, i << 2);
			amp(16'h02BC, 60);
			rdc("nom_used", 12'h01C, pn[i]);
		end
		apb(1, 12'h040, 0);
		amp(16'h0258, 60);
		amp(16'h02BC, 0);
		for (n = 0; n < 99 && start_out !== 1'b1; n++) @(posedge pclk);
		chk("start", 1, start_out);
		chk("trip", 0, trip_out);
		amp(16'h02BC, 30);
		chk("trip", 0, trip_out);
		amp(16'h02BC, 15);
		chk("trip", 1, trip_out);
		amp(16'h0294, 60);
		chk("trip", 1, trip_out);
		amp(16'h0280, 60);
		chk("start", 0, start_out);
		$display("over done");
		amp(16'h02BC, 100);
		for (int m = 0; m < 5; m++) begin
			apb(1, 12'h000, m);
			amp(16'h02BC, 60);
			chk("test", m == 2 || m == 3, test_out);
			chk("blocked", m == 1 || m == 3, blocked_out);
			chk("start", m == 0 || m == 2, start_out);
		end
		apb(1, 12'h000, 0);
		block_in <= 1;
		amp(16'h02BC, 60);
		chk("blocked", 1, blocked_out);
		block_in <= 0;
		amp(16'h0258, 60);
		apb(1, 12'h014, 0);
		apb(1, 12'h010, 6'h3F);
		apb(1, 12'h000, 6'h10);
		chk("trip", 0, trip_out);
		apb(1, 12'h000, 6'h30);
		@(posedge pclk);
		chk("trip", 1, trip_out);
		chk("irq", 0, irq);
		apb(1, 12'h014, 4);
		@(posedge pclk);
		chk("irq", 1, irq);
		rdc("stat", 12'h010, 4);
		apb(1, 12'h010, 4);
		@(posedge pclk);
		chk("irq", 0, irq);
		$display("force done");
		amp(16'h02BC, 0);
		apb(1, 12'h050, 6'h10);
		apb(1, 12'h058, 16'h4E20);
		apb(1, 12'h000, 2);
		apb(1, 12'h004, 1);
		amp(16'h02BC, 60);
		rdc("ctrl", 12'h000, 2);
		chk("start", 0, start_out);
		amp(16'h0280, 60);
		chk("trip", 1, trip_out);
		amp(16'h02A8, 60);
		chk("start", 1, start_out);
		amp(16'h02BC, 60);
		chk("start", 0, start_out);
		$display("under done");
		finish_test;
	end
endmodule : pps_power_stage_test
`default_nettype wire
